// ==== logic/etx_bit_select.sv ====
// per-bit source selection for the outbound e1 stream
// purely combinational; the caller registers the result
`timescale 1ns/10ps
module etx_bit_select
  import etx_pkg::*;
(
  input wire logic [2:0] ohs_code,
  input wire logic sa4_link_enable,
  input wire logic sa4_insert_select,
  input wire logic [1:0] link_source_select,
  input wire logic sa4_reg_value,
  input wire logic [1:0] ts16_source,
  input wire logic ts16_sig_alt,
  input wire logic de_alt,
  input wire logic [4:0] slot,
  input wire logic [2:0] bit_pos,
  input wire logic non_fas,
  input wire logic de_slot,
  input wire logic ser_bit,
  input wire logic frac_bit,
  input wire logic sig_bit,
  input wire logic oh_bit,
  input wire logic reg_bit,
  input wire logic link_bit,
  output logic out_bit
);

  // unused codes fall back to the reset code behaviour
  wire logic code_known = (ohs_code <= OHS_SIG_DE);
  wire logic [2:0] code = code_known ? ohs_code : OHS_DL_SER;
  wire logic nat_ones = (code == OHS_ONES) || (code == OHS_CAS_ONES);
  wire logic cas_on = (code == OHS_CAS_DL) || (code == OHS_CAS_ONES);

  wire logic in_ts0 = (slot == TS_OVERHEAD) && non_fas;
  wire logic nat_pos = in_ts0 && (bit_pos >= SA4_POS);
  wire logic sa4_pos = in_ts0 && (bit_pos == SA4_POS);
  wire logic in_ts16 = (slot == TS_SIGNALING);

  // link bits only ride sa4 when the sa4 link enable and packet source meet
  wire logic sa4_use_link = sa4_link_enable &&
                            (link_source_select == LSRC_PACKET) &&
                            !sa4_insert_select;
  wire logic sa4_bit;
  assign sa4_bit = sa4_insert_select ? sa4_reg_value :
                   sa4_use_link ? link_bit :
                   !sa4_link_enable ? 1'b1 :
                   ser_bit;

  logic cas_bit;
  always_comb begin
    unique case (ts16_source)
      TS16_FROM_SER: cas_bit = ser_bit;
      TS16_FROM_REGS: cas_bit = reg_bit;
      TS16_FROM_OH: cas_bit = oh_bit;
      TS16_FROM_SIG: cas_bit = sig_bit;
    endcase
  end

  wire logic ts16_bit = cas_on ? cas_bit :
                        (code == OHS_ONES) ?
                        (ts16_sig_alt ? sig_bit : ser_bit) :
                        ser_bit;
  wire logic de_bit = (code == OHS_SIG_DE) ?
                      (de_alt ? sig_bit : ser_bit) :
                      (de_alt ? frac_bit : ser_bit);

  always_comb begin
    if (nat_pos && nat_ones) begin
      out_bit = 1'b1;
    end else if (sa4_pos) begin
      out_bit = sa4_bit;
    end else if (in_ts16) begin
      out_bit = ts16_bit;
    end else if (de_slot && !in_ts0) begin
      out_bit = de_bit;
    end else begin
      out_bit = ser_bit;
    end
  end

endmodule : etx_bit_select

// ==== logic/etx_overhead_select.sv ====
// e1 transmit overhead source selector with apb3 register access
// assumes backplane pins asynchronous to pclk and a frame sync pulse pin
`timescale 1ns/10ps
module etx_overhead_select
  import etx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_frame_sync_in,
  input wire logic tx_serial_in,
  input wire logic tx_fractional_data_in,
  input wire logic tx_signaling_in,
  input wire logic tx_overhead_in,
  input wire logic de_slot_active,
  input wire logic link_bit_in,
  output logic tx_line_out,
  output logic tx_frame_sync_out
);

  // pin synchronisers, all five pins share one delay so they stay aligned
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;
  wire logic [4:0] pin_raw = {tx_frame_sync_in, tx_serial_in,
                              tx_fractional_data_in, tx_signaling_in,
                              tx_overhead_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= 5'h00;
    end else begin
      pin_meta_r <= pin_raw;
    end
  end

  // only the second stage feeds logic; the first may be metastable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 5'h00;
    end else begin
      pin_sync_r <= pin_meta_r;
    end
  end
  wire logic fsync_s = pin_sync_r[4];
  wire logic ser_s = pin_sync_r[3];
  wire logic frac_s = pin_sync_r[2];
  wire logic sig_s = pin_sync_r[1];
  wire logic oh_s = pin_sync_r[0];

  // apb decode
  wire logic [IDX_W-1:0] idx = paddr[ADDR_W-1:2];
  wire logic aligned = (paddr[1:0] == 2'h0);
  wire logic hit_sls = aligned && (idx == IDX_SIG_LINK_SEL);
  wire logic hit_aux = aligned && (idx == IDX_SRC_AUX);
  wire logic hit_stat = aligned && (idx == IDX_STATUS);
  wire logic hit_ts16 = aligned && (idx >= IDX_TS16_REG_LO) &&
                        (idx <= IDX_TS16_REG_HI);
  wire logic hit_any = hit_sls || hit_aux || hit_stat || hit_ts16;
  wire logic setup_ph = psel && !penable;
  wire logic wr_go = psel && penable && pready && pwrite && !pslverr;
  wire logic [4:0] ts16_widx = idx[4:0];

  logic [7:0] sig_link_sel_r;
  logic [7:0] src_aux_r;
  logic [7:0] ts16_regs_r [TS16_REGS];

  wire logic wr_sls = wr_go && hit_sls;
  wire logic wr_aux = wr_go && hit_aux;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_link_sel_r <= SIG_LINK_SEL_RST;
    end else if (wr_sls) begin
      sig_link_sel_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_aux_r <= SRC_AUX_RST;
    end else if (wr_aux) begin
      src_aux_r <= pwdata[7:0];
    end
  end

  // signaling byte store for cas insertion
  genvar gi;
  generate
    for (gi = 0; gi < TS16_REGS; gi++) begin : g_ts16
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ts16_regs_r[gi] <= TS16_REG_RST;
        end else if (wr_go && hit_ts16 && (ts16_widx == 5'(gi))) begin
          ts16_regs_r[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // frame position tracking
  logic [7:0] bit_cnt_r;
  logic [4:0] frame_cnt_r;
  logic non_fas_r;
  wire logic [7:0] pos = fsync_s ? 8'h00 : bit_cnt_r;
  wire logic frame_end = (pos == LAST_BIT_POS);
  wire logic [7:0] bit_cnt_nxt = pos + 8'h01;
  wire logic [4:0] frame_cnt_nxt = frame_cnt_r + 5'h01;

  // a sync pulse always wins over the free-running wrap
  wire logic frame_restart = fsync_s;
  wire logic frame_wrap = frame_end && !fsync_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= 8'h00;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_r <= 5'h00;
    end else if (frame_restart) begin
      frame_cnt_r <= 5'h00;
    end else if (frame_wrap) begin
      frame_cnt_r <= frame_cnt_nxt;
    end
  end

  // the frame after a sync is a fas frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      non_fas_r <= 1'b0;
    end else if (frame_restart) begin
      non_fas_r <= 1'b0;
    end else if (frame_wrap) begin
      non_fas_r <= !non_fas_r;
    end
  end

  // stored signaling bit for the current frame, msb sent first
  wire logic [7:0] cur_sig_byte = ts16_regs_r[frame_cnt_r];
  wire logic [2:0] rev_pos = 3'h7 - pos[2:0];
  wire logic reg_bit = cur_sig_byte[rev_pos];

  logic sel_bit;
  etx_bit_select u_sel (
    .ohs_code(sig_link_sel_r[OHS_MSB:OHS_LSB]),
    .sa4_link_enable(sig_link_sel_r[SA4_EN_BIT]),
    .sa4_insert_select(src_aux_r[AUX_SA4_INS_BIT]),
    .link_source_select(src_aux_r[AUX_LSRC_MSB:AUX_LSRC_LSB]),
    .sa4_reg_value(src_aux_r[AUX_SA4_VAL_BIT]),
    .ts16_source(src_aux_r[AUX_TS16_MSB:AUX_TS16_LSB]),
    .ts16_sig_alt(src_aux_r[AUX_TS16_SIG_BIT]),
    .de_alt(src_aux_r[AUX_DE_ALT_BIT]),
    .slot(pos[7:3]),
    .bit_pos(pos[2:0]),
    .non_fas(non_fas_r),
    .de_slot(de_slot_active),
    .ser_bit(ser_s),
    .frac_bit(frac_s),
    .sig_bit(sig_s),
    .oh_bit(oh_s),
    .reg_bit(reg_bit),
    .link_bit(link_bit_in),
    .out_bit(sel_bit)
  );

  wire logic pos_zero = (pos == 8'h00);

  // line idles at one while in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_line_out <= 1'b1;
    end else begin
      tx_line_out <= sel_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_frame_sync_out <= 1'b0;
    end else begin
      tx_frame_sync_out <= pos_zero;
    end
  end

  // read data prepared in setup so the access phase answers at once
  wire logic [31:0] stat_word = {24'h0, 2'h0, frame_cnt_r, tx_line_out};
  wire logic [31:0] rd_mux = hit_sls ? {24'h0, sig_link_sel_r} :
                             hit_aux ? {24'h0, src_aux_r} :
                             hit_stat ? stat_word :
                             hit_ts16 ? {24'h0, ts16_regs_r[ts16_widx]} :
                             32'h0000_0000;

  wire logic pslverr_nxt = !hit_any || (hit_stat && pwrite);
  wire logic [31:0] prdata_nxt = pwrite ? 32'h0000_0000 : rd_mux;

  // zero wait states: every setup is answered in the next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ph;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= pslverr_nxt;
    end
  end

  // held until the next setup so a slow master still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata <= prdata_nxt;
    end
  end

endmodule : etx_overhead_select

// ==== logic/etx_pkg.sv ====
// constants shared by the e1 transmit overhead source selector
// assumes an apb3 register bus with 32-bit data and a 12-bit byte address
package etx_pkg;

  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SIG_LINK_SEL = 10'h10a;
  localparam logic [IDX_W-1:0] IDX_SRC_AUX = 10'h140;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h141;
  localparam logic [IDX_W-1:0] IDX_TS16_REG_LO = 10'h340;
  localparam logic [IDX_W-1:0] IDX_TS16_REG_HI = 10'h35f;

  localparam logic [7:0] SIG_LINK_SEL_RST = 8'h00;
  localparam logic [7:0] SRC_AUX_RST = 8'h00;
  localparam logic [7:0] TS16_REG_RST = 8'h00;

  // fields of tx_signaling_link_select
  localparam int OHS_LSB = 0;
  localparam int OHS_MSB = 2;
  localparam int SA4_EN_BIT = 3;

  // fields of the auxiliary source register
  localparam int AUX_SA4_INS_BIT = 0;
  localparam int AUX_LSRC_LSB = 1;
  localparam int AUX_LSRC_MSB = 2;
  localparam int AUX_SA4_VAL_BIT = 3;
  localparam int AUX_TS16_LSB = 4;
  localparam int AUX_TS16_MSB = 5;
  localparam int AUX_DE_ALT_BIT = 6;
  localparam int AUX_TS16_SIG_BIT = 7;

  // overhead source codes
  localparam logic [2:0] OHS_DL_SER = 3'h0;
  localparam logic [2:0] OHS_CAS_DL = 3'h1;
  localparam logic [2:0] OHS_ONES = 3'h2;
  localparam logic [2:0] OHS_CAS_ONES = 3'h3;
  localparam logic [2:0] OHS_SIG_DE = 3'h4;

  // link source code for the internal packet controller
  localparam logic [1:0] LSRC_PACKET = 2'h1;

  // timeslot 16 sources in cas modes
  localparam logic [1:0] TS16_FROM_SER = 2'h0;
  localparam logic [1:0] TS16_FROM_REGS = 2'h1;
  localparam logic [1:0] TS16_FROM_OH = 2'h2;
  localparam logic [1:0] TS16_FROM_SIG = 2'h3;

  // frame geometry
  localparam logic [7:0] LAST_BIT_POS = 8'hff;
  localparam logic [4:0] TS_OVERHEAD = 5'h00;
  localparam logic [4:0] TS_SIGNALING = 5'h10;
  localparam logic [2:0] SA4_POS = 3'h3;
  localparam int TS16_REGS = 32;

endpackage : etx_pkg

// ==== testbench/etx_overhead_select_props.sv ====
// concurrent checks on the overhead source selector ports
// assumes one pclk domain; bound to every instance below
`timescale 1ns/10ps
module etx_overhead_select_props
  import etx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_serial_in,
  input wire logic tx_signaling_in,
  input wire logic de_slot_active,
  input wire logic tx_line_out,
  input wire logic tx_frame_sync_out
);
  logic [7:0] pos_r, aux_r;
  logic [3:0] cfg_r;
  logic [2:0] q_r;
  logic par_r, st_r;
  wire wr = psel && penable && pready && pwrite && !pslverr;
  // line checks wait until a config write has surely landed
  wire ok = st_r && q_r == 3'h7;
  wire nf = ok && !par_r;
  wire [2:0] cd = cfg_r[2:0];
  wire ones = cd == OHS_ONES || cd == OHS_CAS_ONES;
  wire ts = ok && pos_r[7:3] == 5'h10 && !de_slot_active;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pos_r, aux_r, cfg_r, q_r, par_r, st_r} <= '0;
    end else begin
      pos_r <= tx_frame_sync_out ? 8'h01 : pos_r + 8'h01;
      if (tx_frame_sync_out && pos_r != 8'h00) {st_r, par_r} <= 2'h3;
      else if (pos_r == 8'hff) par_r <= !par_r;
      q_r <= wr ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
      if (wr && paddr == 12'h428) cfg_r <= pwdata[3:0];
      if (wr && paddr == 12'h500) aux_r <= pwdata[7:0];
    end
  end
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready");
  a_cfg_read: assert property (
    pready && !pwrite && paddr == 12'h428 |-> prdata[3:0] == cfg_r)
    else $error("select readback");
  a_aux_read: assert property (
    pready && !pwrite && paddr == 12'h500 |-> prdata[7:0] == aux_r)
    else $error("aux readback");
  a_sa4_ones: assert property (
    nf && pos_r == 8'h03 && !cfg_r[3] && !aux_r[0] |-> tx_line_out)
    else $error("sa4 not one");
  a_nat_forced: assert property (
    nf && pos_r >= 8'h03 && pos_r <= 8'h07 && ones |-> tx_line_out)
    else $error("national not one");
  a_sa4_reg: assert property (
    nf && pos_r == 8'h03 && !ones && aux_r[0] |-> tx_line_out == aux_r[3])
    else $error("sa4 reg value");
  a_ts16_ser: assert property (
    ts && (cd == OHS_DL_SER || cd == OHS_SIG_DE)
    |-> tx_line_out == $past(tx_serial_in, 3)) else $error("ts16 serial");
  a_ts16_sig: assert property (
    ts && cd == OHS_ONES && aux_r[7]
    |-> tx_line_out == $past(tx_signaling_in, 3)) else $error("ts16 sig");
endmodule : etx_overhead_select_props
bind etx_overhead_select etx_overhead_select_props props_inst (.*);

// ==== testbench/etx_src_model.sv ====
// backplane source model: one frame sync pulse, then steady pin levels
// assumes the bench sets the levels between scenarios
`timescale 1ns/10ps
module etx_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] lv,
  output logic [6:0] pins
);
  logic [3:0] c_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c_r <= 4'h0;
    else if (c_r != 4'hf) c_r <= c_r + 4'h1;
  end
  // a single sync: the line side must keep frame count on its own
  assign pins = {c_r == 4'h4, lv};
endmodule : etx_src_model

// ==== testbench/tb.sv ====
// bench for the overhead source selector: apb setup, then mode frames
// assumes the source model drives the backplane pins
`timescale 1ns/10ps
module tb;
  import etx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic line, fso;
  logic par = 1'b0;
  logic st = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pos = 8'h00;
  logic [7:0] c, a;
  logic [6:0] pins;
  logic [5:0] lv, l;
  logic [3:0] x;
  logic [255:0] f;
  int n_errors, checks;
  // code, aux, {de,link,oh,sig,frac,ser}, expected {sa4,sa8,de,ts16}
  // only codes 000 to 100 are programmed; 101 to 111 stay unused
  logic [25:0] tbl [14] = '{
    {8'h08, 8'h02, 6'h10, 4'h8}, {8'h08, 8'h02, 6'h21, 4'h7},
    {8'h00, 8'h00, 6'h1e, 4'h8}, {8'h08, 8'h03, 6'h11, 4'h7},
    {8'h08, 8'h0b, 6'h00, 4'h8}, {8'h08, 8'h04, 6'h10, 4'h0},
    {8'h02, 8'hc0, 6'h06, 4'hd}, {8'h02, 8'h40, 6'h22, 4'he},
    {8'h01, 8'h10, 6'h00, 4'h9}, {8'h03, 8'h20, 6'h08, 4'hd},
    {8'h01, 8'h30, 6'h04, 4'h9}, {8'h01, 8'h00, 6'h1e, 4'h8},
    {8'h04, 8'h40, 6'h24, 4'ha}, {8'h04, 8'h40, 6'h22, 4'h8}};
  etx_overhead_select etx_overhead_select_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_frame_sync_in(pins[6]), .tx_serial_in(pins[0]),
    .tx_fractional_data_in(pins[1]), .tx_signaling_in(pins[2]),
    .tx_overhead_in(pins[3]), .de_slot_active(pins[5]),
    .link_bit_in(pins[4]), .tx_line_out(line), .tx_frame_sync_out(fso));
  etx_src_model etx_src_model_inst (.pclk, .presetn, .lv, .pins);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    pos <= fso ? 8'h01 : pos + 8'h01;
    if (fso && pos != 8'h00) {st, par} <= 2'h3;
    else if (pos == 8'hff) par <= !par;
  end
  task wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    if (n == 64) n_errors++;
  endtask : apb
  // waits for bit 0 of a non-fas frame, then records its first slots
  task grab;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(st && !par && pos == 8'h00) && n < 1024);
    if (n == 1024) n_errors++;
    for (int i = 0; i < 136; i++) begin
      f[i] = line;
      @(posedge pclk);
    end
  endtask : grab
  initial begin
    #150000;
    n_errors++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, lv} = '0;
    {presetn, n_errors, checks} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h428, '0);
    chk("select reset", '0, rd);
    apb(1'b0, 12'h500, '0);
    chk("aux reset", '0, rd);
    apb(1'b1, 12'h428, 32'h0000_00fb);
    apb(1'b0, 12'h428, '0);
    chk("select", 32'h0000_00fb, rd);
    apb(1'b1, 12'h504, '0);
    chk("status write", 32'h1, 32'(er));
    apb(1'b0, 12'h42c, '0);
    chk("unmapped", 32'h1, 32'(er));
    apb(1'b0, 12'h504, '0);
    chk("status read", 32'h0, 32'(er));
    for (int i = 0; i < 32; i++) apb(1'b1, 12'hd00 + 12'(4 * i), 32'h80);
    foreach (tbl[k]) begin
      {c, a, l, x} = tbl[k];
      apb(1'b1, 12'h428, {24'h0, c});
      apb(1'b1, 12'h500, {24'h0, a});
      lv <= l;
      repeat (8) @(posedge pclk);
      grab();
      chk("sa4", 32'(x[3]), 32'(f[3]));
      chk("sa8", 32'(x[2]), 32'(f[7]));
      chk("d/e", 32'(x[1]), 32'(f[40]));
      if (!l[5]) chk("ts16", 32'(x[0]), 32'(f[128]));
    end
    wrap_up();
  end
endmodule : tb
